// ### design/sps_ctrl.sv
// Controller end: rail order, clock start, reset, waits and stream control.
`timescale 1ns/100ps

module sps_ctrl
	import sps_pkg::*;
#(
	parameter int unsigned RST_CYC = HARD_RST_CYC,
	parameter int unsigned INIT_WAIT = INIT_EXT_CYC,
	parameter int unsigned LOCK_CYC = PLL_LOCK_CYC,
	parameter int unsigned OFF_CYC = OFF_GAP_CYC
) (
	input wire logic clk, // System clock.
	input wire logic sys_rst, // Synchronous reset, active high.
	sps_if.ctrl lnk, // Link to the sensor.
	input wire logic power_up, // Pulse: run the power-up sequence.
	input wire logic power_down, // Pulse: run the power-down sequence.
	input wire logic cfg_valid, // User settings write request.
	input wire logic [15:0] cfg_addr, // Settings register address.
	input wire logic [15:0] cfg_data, // Settings register data.
	input wire logic cfg_last, // Marks the final settings write.
	output logic cfg_ready, // High the cycle after a settings write is taken.
	output logic clk_stop, // Input clock held low from reset or the power-down standby until the rails settle.
	output logic active // Sensor streaming under control.
);

	initial begin
		if (RST_CYC < 1 || INIT_WAIT < 1 || LOCK_CYC < 1 || OFF_CYC < 1) begin
			$error("sps_ctrl: bad parameters");
		end
	end

	typedef enum logic [3:0] {
		S_OFF, S_RAILS_UP, S_SETTLE, S_RESET, S_INIT, S_CONFIG,
		S_LOCK, S_STREAM, S_STOPPING, S_RAILS_DN, S_COOL
	} sps_ctrl_state_t;

	sps_ctrl_state_t st_q, st_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [2:0] idx_q, idx_d;
	logic [4:0] rail_q, rail_d;
	logic ck_off_q, ck_off_d;
	logic [2:0] div_q, div_d;
	logic ext_q, ext_d;
	logic rst_n_q, rst_n_d;
	logic wv_q, wv_d;
	logic [15:0] wa_q, wa_d;
	logic [15:0] wd_q, wd_d;
	logic rdy_q, rdy_d;
	logic act_q, act_d;
	logic [1:0] sb_sync_q;
	logic ext_edge;

	// Rail position for the given step of the up order.
	function automatic int up_rail(input logic [2:0] i);
		case (i)
			3'h0: up_rail = RAIL_PLL;
			3'h1: up_rail = RAIL_ANA;
			3'h2: up_rail = RAIL_IO;
			3'h3: up_rail = RAIL_CORE;
			default: up_rail = RAIL_SER;
		endcase
	endfunction

	// Standby flag is from the far end; pass it through two flops.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sb_sync_q <= 2'h0;
		end else begin
			sb_sync_q <= {sb_sync_q[0], lnk.soft_standby};
		end
	end

	// Input clock divider runs only while enabled.
	always_comb begin
		ext_edge = !ck_off_q && (div_q == 3'(EXT_HALF_CYC - 1));
		div_d = (ext_edge || ck_off_q) ? 3'h0 : div_q + 3'h1;
		ext_d = ck_off_q ? 1'b0 : (ext_edge ? ~ext_q : ext_q);
	end

	// Main sequencing state machine.
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		idx_d = idx_q;
		rail_d = rail_q;
		ck_off_d = ck_off_q;
		rst_n_d = rst_n_q;
		wv_d = 1'b0;
		wa_d = wa_q;
		wd_d = wd_q;
		rdy_d = 1'b0;
		act_d = act_q;
		case (st_q)
			S_OFF: begin
				if (power_up) begin
					st_d = S_RAILS_UP;
					idx_d = 3'h0;
					cnt_d = '0;
					rst_n_d = 1'b0;
				end
			end
			S_RAILS_UP: begin
				// PLL rail is always the first step.
				if (cnt_q == 0) begin
					rail_d[up_rail(idx_q)] = 1'b1;
				end
				cnt_d = cnt_q + 1'b1;
				if (cnt_q >= STEP_GAP_CYC) begin
					cnt_d = '0;
					idx_d = idx_q + 3'h1;
					if (idx_q == 3'(RAIL_N - 1)) begin
						st_d = S_SETTLE;
					end
				end
			end
			S_SETTLE: begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q >= SETTLE_CYC) begin
					ck_off_d = 1'b0;
					cnt_d = '0;
					st_d = S_RESET;
				end
			end
			S_RESET: begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q >= RST_CYC) begin
					rst_n_d = 1'b1;
					cnt_d = '0;
					st_d = S_INIT;
				end
			end
			S_INIT: begin
				// Count input clock rising edges; no writes meanwhile.
				if (ext_edge && !ext_q) begin
					cnt_d = cnt_q + 1'b1;
				end
				if (cnt_q >= INIT_WAIT) begin
					cnt_d = '0;
					st_d = S_CONFIG;
				end
			end
			S_CONFIG: begin
				if (cfg_valid && lnk.wr_ready &&
					!rdy_q && !wv_q) begin
					wv_d = 1'b1;
					wa_d = cfg_addr;
					wd_d = cfg_data;
					rdy_d = 1'b1;
					if (cfg_last) begin
						st_d = S_LOCK;
					end
				end
			end
			S_LOCK: begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q >= LOCK_CYC) begin
					wv_d = 1'b1;
					wa_d = MODE_REG_ADDR;
					wd_d = STREAM_ON;
					act_d = 1'b1;
					cnt_d = '0;
					st_d = S_STREAM;
				end
			end
			S_STREAM: begin
				if (power_down) begin
					wv_d = 1'b1;
					wa_d = MODE_REG_ADDR;
					wd_d = STREAM_OFF;
					cnt_d = '0;
					st_d = S_STOPPING;
				end
			end
			S_STOPPING: begin
				// Give the standby flag time to fall, then await it.
				if (cnt_q < 4) begin
					cnt_d = cnt_q + 1'b1;
				end else if (sb_sync_q[1]) begin
					ck_off_d = 1'b1;
					rst_n_d = 1'b0;
					act_d = 1'b0;
					idx_d = 3'h0;
					cnt_d = '0;
					st_d = S_RAILS_DN;
				end
			end
			S_RAILS_DN: begin
				if (cnt_q == 0) begin
					// Clock already stopped; order is the up order reversed.
					rail_d[up_rail(3'(RAIL_N - 1) - idx_q)] = 1'b0;
				end
				cnt_d = cnt_q + 1'b1;
				if (cnt_q >= STEP_GAP_CYC) begin
					cnt_d = '0;
					idx_d = idx_q + 3'h1;
					if (idx_q == 3'(RAIL_N - 1)) begin
						st_d = S_COOL;
					end
				end
			end
			S_COOL: begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q >= OFF_CYC) begin
					cnt_d = '0;
					st_d = S_OFF;
				end
			end
			default: begin
				st_d = S_OFF;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q <= S_OFF;
			cnt_q <= '0;
			idx_q <= 3'h0;
			rail_q <= RAILS_OFF;
			ck_off_q <= 1'b1;
			div_q <= 3'h0;
			ext_q <= 1'b0;
			rst_n_q <= 1'b0;
			wv_q <= 1'b0;
			wa_q <= 16'h0000;
			wd_q <= 16'h0000;
			rdy_q <= 1'b0;
			act_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			idx_q <= idx_d;
			rail_q <= rail_d;
			ck_off_q <= ck_off_d;
			div_q <= div_d;
			ext_q <= ext_d;
			rst_n_q <= rst_n_d;
			wv_q <= wv_d;
			wa_q <= wa_d;
			wd_q <= wd_d;
			rdy_q <= rdy_d;
			act_q <= act_d;
		end
	end

	// Link and user outputs, all from flip-flops.
	assign lnk.rail_en = rail_q;
	assign lnk.external_input_clock = ext_q;
	assign lnk.reset_n = rst_n_q;
	assign lnk.wr_valid = wv_q;
	assign lnk.wr_addr = wa_q;
	assign lnk.wr_data = wd_q;
	assign cfg_ready = rdy_q;
	assign clk_stop = ck_off_q;
	assign active = act_q;

endmodule

// ### design/sps_if.sv
// Interface joining the power controller and the sensor sequencing model.
`timescale 1ns/100ps
interface sps_if;
	logic [4:0] rail_en;
	logic external_input_clock;
	logic reset_n;
	logic wr_valid;
	logic [15:0] wr_addr;
	logic [15:0] wr_data;
	logic wr_ready;
	logic soft_standby;

	modport ctrl (
		output rail_en,
		output external_input_clock,
		output reset_n,
		output wr_valid,
		output wr_addr,
		output wr_data,
		input wr_ready,
		input soft_standby
	);
	modport sensor (
		input rail_en,
		input external_input_clock,
		input reset_n,
		input wr_valid,
		input wr_addr,
		input wr_data,
		output wr_ready,
		output soft_standby
	);
endinterface

// ### design/sps_pkg.sv
// Package with shared constants and types for the sensor power sequencer.
package sps_pkg;

	// Clock rate of the controller clock in kHz (125 MHz).
	localparam int unsigned CLK_KHZ = 125000;
	// Rail enable vector bit positions.
	localparam int RAIL_PLL = 0;
	localparam int RAIL_ANA = 1;
	localparam int RAIL_IO = 2;
	localparam int RAIL_CORE = 3;
	localparam int RAIL_SER = 4;
	localparam int RAIL_N = 5;
	localparam logic [4:0] RAILS_OFF = 5'h00;
	// Gap between rail steps in microseconds.
	localparam int unsigned STEP_GAP_US = 10;
	localparam int unsigned STEP_GAP_CYC = STEP_GAP_US * CLK_KHZ / 1000;
	// Rail settle time before the clock starts, in microseconds.
	localparam int unsigned SETTLE_US = 10;
	localparam int unsigned SETTLE_CYC = SETTLE_US * CLK_KHZ / 1000;
	// Hard reset low time in milliseconds.
	localparam int unsigned HARD_RST_MS = 1;
	localparam int unsigned HARD_RST_CYC = HARD_RST_MS * CLK_KHZ;
	// Internal initialization in input clock cycles.
	localparam int unsigned INIT_EXT_CYC = 160000;
	// PLL lock wait in milliseconds.
	localparam int unsigned PLL_LOCK_MS = 1;
	localparam int unsigned PLL_LOCK_CYC = PLL_LOCK_MS * CLK_KHZ;
	// Power-down to next power-up gap in milliseconds.
	localparam int unsigned OFF_GAP_MS = 100;
	localparam int unsigned OFF_GAP_CYC = OFF_GAP_MS * CLK_KHZ;
	// Clock divider half period for the external input clock.
	localparam int unsigned EXT_HALF_CYC = 3;
	// Register address and bit of the streaming control.
	localparam logic [15:0] MODE_REG_ADDR = 16'h301A;
	localparam int STREAM_BIT = 2;
	localparam logic [15:0] STREAM_ON = 16'h0004;
	localparam logic [15:0] STREAM_OFF = 16'h0000;
	// Counter width for long counts.
	localparam int CNT_W = 32;

	typedef enum logic [1:0] {
		SPS_DEV_OFF,
		SPS_DEV_INIT,
		SPS_DEV_STANDBY,
		SPS_DEV_STREAM
	} sps_dev_state_t;

endpackage

// ### design/sps_sensor.sv
// Sensor end: initialization, standby and stream stop at row or frame end.
`timescale 1ns/100ps
module sps_sensor
	import sps_pkg::*;
#(
	parameter int unsigned INIT_CYC = INIT_EXT_CYC,
	parameter int unsigned ROW_CYC = 16,
	parameter int unsigned ROWS = 8
) (
	input wire logic clk, // System clock.
	input wire logic sys_rst, // Synchronous reset, active high.
	sps_if.sensor lnk, // Link to the controller.
	input wire logic stop_at_frame, // High: finish frame, low: row.
	output logic streaming, // Sensor is producing output.
	output logic frame_start // One-cycle pulse at each frame start.
);

	initial begin
		if (INIT_CYC < 1 || ROW_CYC < 2 || ROWS < 1) begin
			$error("sps_sensor: bad parameters");
		end
	end

	logic [2:0] ck_sync_q;
	logic [2:0] ck_sync_d;
	logic [1:0] rn_sync_q;
	logic [1:0] rn_sync_d;
	sps_dev_state_t st_q;
	sps_dev_state_t st_d;
	logic [CNT_W-1:0] init_q;
	logic [CNT_W-1:0] init_d;
	logic [15:0] col_q;
	logic [15:0] col_d;
	logic [15:0] row_q;
	logic [15:0] row_d;
	logic stop_req_q;
	logic stop_req_d;
	logic stream_q;
	logic stream_d;
	logic fs_q;
	logic fs_d;
	logic sb_q;
	logic sb_d;
	logic wrdy_q;
	logic wrdy_d;
	logic ck_rise;
	logic row_end;
	logic frame_end;
	logic powered;

	// Synchronisers for the clock and reset pins, plus an edge stage.
	always_comb begin
		ck_sync_d = {ck_sync_q[1:0], lnk.external_input_clock};
		rn_sync_d = {rn_sync_q[0], lnk.reset_n};
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ck_sync_q <= 3'h0;
			rn_sync_q <= 2'h0;
		end else begin
			ck_sync_q <= ck_sync_d;
			rn_sync_q <= rn_sync_d;
		end
	end

	// Rails are level inputs from logic; the sensor needs them all up.
	always_comb begin
		powered = &lnk.rail_en;
		ck_rise = ck_sync_q[1] & ~ck_sync_q[2];
		row_end = ck_rise && (col_q == 16'(ROW_CYC - 1));
		frame_end = row_end && (row_q == 16'(ROWS - 1));
	end

	// Sequencing state machine of the sensor.
	always_comb begin
		st_d = st_q;
		init_d = init_q;
		col_d = col_q;
		row_d = row_q;
		stop_req_d = stop_req_q;
		fs_d = 1'b0;
		if (!powered || !rn_sync_q[1]) begin
			st_d = SPS_DEV_OFF;
			init_d = '0;
			col_d = '0;
			row_d = '0;
			stop_req_d = 1'b0;
		end else begin
			case (st_q)
				SPS_DEV_OFF: begin
					st_d = SPS_DEV_INIT;
				end
				SPS_DEV_INIT: begin
					// Count input clocks, then settle into standby.
					if (ck_rise) begin
						init_d = init_q + 1'b1;
					end
					if (init_q >= INIT_CYC) begin
						st_d = SPS_DEV_STANDBY;
					end
				end
				SPS_DEV_STANDBY: begin
					if (lnk.wr_valid && lnk.wr_addr == MODE_REG_ADDR &&
						lnk.wr_data[STREAM_BIT]) begin
						st_d = SPS_DEV_STREAM;
						col_d = '0;
						row_d = '0;
						stop_req_d = 1'b0;
						fs_d = 1'b1;
					end
				end
				SPS_DEV_STREAM: begin
					if (lnk.wr_valid && lnk.wr_addr == MODE_REG_ADDR) begin
						stop_req_d = ~lnk.wr_data[STREAM_BIT];
					end
					if (ck_rise) begin
						col_d = row_end ? 16'h0000 : col_q + 16'h0001;
						if (row_end) begin
							row_d = frame_end ? 16'h0000 : row_q + 16'h0001;
						end
						if (frame_end && !stop_req_q) begin
							fs_d = 1'b1;
						end
					end
					// Stop only on the selected boundary.
					if (stop_req_q &&
						(stop_at_frame ? frame_end : row_end)) begin
						st_d = SPS_DEV_STANDBY;
					end
				end
				default: begin
					st_d = SPS_DEV_OFF;
				end
			endcase
		end
		stream_d = (st_d == SPS_DEV_STREAM);
		sb_d = (st_d == SPS_DEV_STANDBY);
		wrdy_d = (st_d == SPS_DEV_STANDBY) || (st_d == SPS_DEV_STREAM);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q <= SPS_DEV_OFF;
			init_q <= '0;
			col_q <= 16'h0000;
			row_q <= 16'h0000;
			stop_req_q <= 1'b0;
			stream_q <= 1'b0;
			fs_q <= 1'b0;
			sb_q <= 1'b0;
			wrdy_q <= 1'b0;
		end else begin
			st_q <= st_d;
			init_q <= init_d;
			col_q <= col_d;
			row_q <= row_d;
			stop_req_q <= stop_req_d;
			stream_q <= stream_d;
			fs_q <= fs_d;
			sb_q <= sb_d;
			wrdy_q <= wrdy_d;
		end
	end

	// Status back to the controller and user.
	assign lnk.wr_ready = wrdy_q; // Writes are taken once initialised.
	assign lnk.soft_standby = sb_q;
	assign streaming = stream_q;
	assign frame_start = fs_q;

endmodule

// ### sim/sps_assertions.sv
// Checker of the link between the power controller and the sensor.
`timescale 1ns/100ps
module sps_assertions
	import sps_pkg::*;
#(
	parameter int unsigned RST_CYC = 20,
	parameter int unsigned INIT_WAIT = 30,
	parameter int unsigned LOCK_CYC = 20,
	parameter int unsigned OFF_CYC = 50
) (
	input wire logic clk, // System clock.
	input wire logic sys_rst, // Synchronous reset.
	input wire logic [4:0] rail_en, // Rail enables.
	input wire logic external_input_clock, // Sensor input clock.
	input wire logic reset_n, // Hard reset, active low.
	input wire logic wr_valid, // Write strobe.
	input wire logic [15:0] wr_addr, // Write address.
	input wire logic [15:0] wr_data, // Write data.
	input wire logic wr_ready, // Sensor takes writes.
	input wire logic soft_standby // Sensor standby flag.
);
	localparam int STOP_MAX = 400;
	logic [31:0] low_q, ext_q, gap_q, off_q;
	logic ext_q1;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Counters of reset low time, input clock rises, write gap, rails off.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			low_q <= '0;
			ext_q <= '0;
			gap_q <= '0;
			off_q <= OFF_CYC;
			ext_q1 <= 1'b0;
		end else begin
			ext_q1 <= external_input_clock;
			low_q <= (!reset_n && rail_en == 5'h1f) ? low_q + 1 : '0;
			ext_q <= !reset_n ? '0 : ext_q + (external_input_clock && !ext_q1);
			gap_q <= wr_valid ? '0 : gap_q + 1;
			off_q <= (rail_en == RAILS_OFF) ? off_q + 1 : '0;
		end
	end
	sequence s_start;
		wr_valid && wr_addr == MODE_REG_ADDR && wr_data == STREAM_ON;
	endsequence
	sequence s_stop;
		wr_valid && wr_addr == MODE_REG_ADDR && wr_data == STREAM_OFF;
	endsequence
	property p_pll_first;
		rail_en != RAILS_OFF |-> rail_en[RAIL_PLL];
	endproperty
	a_pll_first: assert property (p_pll_first)
		else $error("rail on without the PLL rail");
	property p_rail_up;
		rail_en > $past(rail_en) |-> rail_en == {$past(rail_en[3:0]), 1'b1};
	endproperty
	a_rail_up: assert property (p_rail_up)
		else $error("rails raised out of order");
	property p_rail_down;
		rail_en < $past(rail_en) |-> rail_en == ($past(rail_en) >> 1);
	endproperty
	a_rail_down: assert property (p_rail_down)
		else $error("rails removed out of order");
	property p_clk_start;
		$rose(external_input_clock) |-> rail_en == 5'h1f;
	endproperty
	a_clk_start: assert property (p_clk_start)
		else $error("input clock runs before all rails");
	property p_rst_hold;
		$rose(reset_n) |-> low_q >= RST_CYC;
	endproperty
	a_rst_hold: assert property (p_rst_hold)
		else $error("hard reset released too early");
	property p_init_wait;
		wr_valid |-> ext_q >= INIT_WAIT;
	endproperty
	a_init_wait: assert property (p_init_wait)
		else $error("write before initialization ended");
	property p_lock_wait;
		s_start |-> gap_q >= LOCK_CYC - 1;
	endproperty
	a_lock_wait: assert property (p_lock_wait)
		else $error("stream started before lock time");
	property p_stop_standby;
		s_stop |-> ##[1:STOP_MAX] soft_standby;
	endproperty
	a_stop_standby: assert property (p_stop_standby)
		else $error("standby not reached after stop");
	property p_start_stream;
		s_start |-> ##[1:20] !soft_standby;
	endproperty
	a_start_stream: assert property (p_start_stream)
		else $error("sensor stayed in standby after start");
	property p_down_order;
		$fell(rail_en[RAIL_SER]) |-> !reset_n && !external_input_clock;
	endproperty
	a_down_order: assert property (p_down_order)
		else $error("rail removed with clock or reset active");
	property p_off_gap;
		$rose(rail_en[RAIL_PLL]) |-> off_q >= OFF_CYC;
	endproperty
	a_off_gap: assert property (p_off_gap)
		else $error("power-up too soon after power-down");
	property p_write_ready;
		wr_valid |-> wr_ready;
	endproperty
	a_write_ready: assert property (p_write_ready)
		else $error("write sent while the sensor refuses writes");
endmodule

// ### sim/testbench.sv
// Self-checking bench for both ends of the sensor power sequencer.
`timescale 1ns/100ps
module testbench;
	import sps_pkg::*;
	localparam int unsigned RST = 20, INW = 30, LCK = 20, OFF = 50;
	localparam int unsigned ROWC = 4, NROW = 2;
	typedef struct {logic [15:0] a; logic [15:0] d; logic l;} sps_row_t;
	logic clk, sys_rst, power_up, power_down, cfg_valid, cfg_last;
	logic [15:0] cfg_addr, cfg_data;
	logic cfg_ready, clk_stop, active, stop_at_frame, streaming, frame_start;
	int err_total, num_checks, cyc, t0, tf;
	sps_row_t rows[3];
	sps_if i_sps_if();
	sps_ctrl #(.RST_CYC(RST), .INIT_WAIT(INW), .LOCK_CYC(LCK), .OFF_CYC(OFF))
		i_sps_ctrl (.clk(clk), .sys_rst(sys_rst), .lnk(i_sps_if.ctrl),
		.power_up(power_up), .power_down(power_down), .cfg_valid(cfg_valid),
		.cfg_addr(cfg_addr), .cfg_data(cfg_data), .cfg_last(cfg_last),
		.cfg_ready(cfg_ready), .clk_stop(clk_stop), .active(active));
	sps_sensor #(.INIT_CYC(INW), .ROW_CYC(ROWC), .ROWS(NROW))
		i_sps_sensor (.clk(clk), .sys_rst(sys_rst), .lnk(i_sps_if.sensor),
		.stop_at_frame(stop_at_frame), .streaming(streaming),
		.frame_start(frame_start));
	sps_assertions #(.RST_CYC(RST), .INIT_WAIT(INW), .LOCK_CYC(LCK),
		.OFF_CYC(OFF)) i_sps_assertions (.clk(clk), .sys_rst(sys_rst),
		.rail_en(i_sps_if.rail_en),
		.external_input_clock(i_sps_if.external_input_clock),
		.reset_n(i_sps_if.reset_n), .wr_valid(i_sps_if.wr_valid),
		.wr_addr(i_sps_if.wr_addr), .wr_data(i_sps_if.wr_data),
		.wr_ready(i_sps_if.wr_ready),
		.soft_standby(i_sps_if.soft_standby));
	// Clock generation.
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Cycle count, last frame start, and the hang limit.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (frame_start === 1'b1) tf <= cyc;
		if (cyc == 40000) begin
			err_total++;
			stop_test;
		end
	end
	task automatic chk(string n, logic [15:0] e, logic [15:0] s);
		num_checks++;
		if (s !== e) begin
			err_total++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	function automatic logic sig(int s);
		case (s)
			0: return i_sps_if.reset_n;
			1: return i_sps_if.soft_standby;
			2: return active;
			3: return streaming;
			4: return i_sps_if.rail_en == RAILS_OFF;
			default: return i_sps_if.wr_valid;
		endcase
	endfunction
	// Waits a bounded time for a signal to reach a level.
	task automatic wt(int s, logic v, int lim);
		int n;
		n = 0;
		while (sig(s) !== v && n < lim) begin
			@(negedge clk);
			n++;
		end
		chk($sformatf("wait %0d", s), {15'h0000, v}, {15'h0000, sig(s)});
	endtask
	// One settings request; reports whether it was taken.
	task automatic cfg(sps_row_t r, output logic got);
		cfg_addr = r.a;
		cfg_data = r.d;
		cfg_last = r.l;
		cfg_valid = 1'b1;
		@(negedge clk);
		cfg_valid = 1'b0;
		got = 1'b0;
		repeat (3) begin
			if (cfg_ready === 1'b1 && !got) begin
				got = 1'b1;
				chk("wr_valid", 16'h0001, {15'h0000, i_sps_if.wr_valid});
				chk("wr_addr", r.a, i_sps_if.wr_addr);
				chk("wr_data", r.d, i_sps_if.wr_data);
			end
			@(negedge clk);
		end
	endtask
	task automatic pulse(logic dn);
		power_up = !dn;
		power_down = dn;
		@(negedge clk);
		power_up = 1'b0;
		power_down = 1'b0;
	endtask
	task automatic run_up(logic frm);
		logic got;
		stop_at_frame = frm;
		cfg(rows[0], got);
		chk("early cfg", 16'h0000, {15'h0000, got});
		pulse(1'b0);
		wt(0, 1'b1, 8000);
		chk("rails", 16'h001f, {11'h000, i_sps_if.rail_en});
		cfg(rows[0], got);
		chk("init cfg", 16'h0000, {15'h0000, got});
		wt(1, 1'b1, 1000);
		foreach (rows[i]) begin
			got = 1'b0;
			for (int k = 0; k < 200 && !got; k++) cfg(rows[i], got);
			chk("cfg taken", 16'h0001, {15'h0000, got});
		end
		wt(2, 1'b1, LCK + 100);
		chk("mode addr", MODE_REG_ADDR, i_sps_if.wr_addr);
		chk("mode data", STREAM_ON, i_sps_if.wr_data);
		wt(3, 1'b1, 200);
		$display("power-up test done");
	endtask
	task automatic run_down(logic frm);
		pulse(1'b1);
		wt(5, 1'b1, 4);
		chk("stop addr", MODE_REG_ADDR, i_sps_if.wr_addr);
		chk("stop data", STREAM_OFF, i_sps_if.wr_data);
		t0 = cyc;
		wt(3, 1'b0, 400);
		if (frm) begin
			chk("frame end", 16'h0001, 16'((cyc - tf) inside {[42:60]}));
		end else begin
			chk("row end", 16'h0001, 16'(cyc - t0 <= 36));
		end
		wt(1, 1'b1, 100);
		wt(2, 1'b0, 100);
		wt(4, 1'b1, 7000);
		chk("clk_stop", 16'h0001, {15'h0000, clk_stop});
		// Last rail step still runs; ask for power-up midway through cool.
		repeat (STEP_GAP_CYC + OFF / 2) @(negedge clk);
		pulse(1'b0);
		repeat (OFF / 2) @(negedge clk);
		chk("cool", 16'h0000, {11'h000, i_sps_if.rail_en});
		repeat (OFF) @(negedge clk);
		$display("power-down test done");
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Main sequence: reset, two power cycles in row and frame modes.
	initial begin
		{err_total, num_checks, cyc, tf} = '0;
		sys_rst = 1'b1;
		{power_up, power_down, cfg_valid, cfg_last} = 4'h0;
		cfg_addr = 16'h0000;
		cfg_data = 16'h0000;
		stop_at_frame = 1'b0;
		rows[0] = '{16'h302E, 16'h0002, 1'b0};
		rows[1] = '{16'h3012, 16'h0100, 1'b0};
		rows[2] = '{16'h3030, 16'h0020, 1'b1};
		repeat (16) @(negedge clk);
		chk("rst rails", 16'h0000, {11'h000, i_sps_if.rail_en});
		chk("rst reset_n", 16'h0000, {15'h0000, i_sps_if.reset_n});
		chk("rst clk_stop", 16'h0001, {15'h0000, clk_stop});
		sys_rst = 1'b0;
		@(negedge clk);
		$display("reset test done");
		run_up(1'b0);
		pulse(1'b0);
		repeat (4) @(negedge clk);
		chk("up in stream", 16'h001f, {11'h000, i_sps_if.rail_en});
		run_down(1'b0);
		run_up(1'b1);
		run_down(1'b1);
		stop_test;
	end
endmodule
